// ### shared/serial_port_handshake_mailbox_pkg.sv
// constants, modes and carriers for the serial port handshake and mailbox block
package serial_port_handshake_mailbox_pkg;
    localparam int NUM_PORTS = 5;
    localparam int DATA_W = 16;
    localparam int REG_NUM_W = 13;
    localparam int MBOX_DEPTH = 2048;
    localparam int RACK_WINDOW = 15;
    localparam int CLOCK_HZ = 50_000_000;
    localparam int CTS_STEP_MS = 10;
    localparam int CTS_STEP_CYCLES = (CLOCK_HZ / 1000) * CTS_STEP_MS;

    localparam logic [REG_NUM_W-1:0] MBOX_FIRST = 13'h0001;
    localparam logic [REG_NUM_W-1:0] MBOX_LAST = 13'h0800;
    localparam logic [REG_NUM_W-1:0] STAT_REG [NUM_PORTS] = '{13'h07f8, 13'h0818, 13'h0838, 13'h0858, 13'h0878};
    localparam logic [REG_NUM_W-1:0] PAD_REG [NUM_PORTS] = '{13'h1f60, 13'h1f80, 13'h1fa0, 13'h1fc0, 13'h1fe0};
    // index 0 unused: port 0 has no clear-to-send line
    localparam logic [REG_NUM_W-1:0] RR_DELAY_REG [NUM_PORTS] = '{13'h0000, 13'h1f6a, 13'h1f8a, 13'h1faa, 13'h1fca};

    localparam logic [DATA_W-1:0] PAD_MIN = 16'h000a;
    localparam logic [DATA_W-1:0] PAD_RESET = 16'h000a;
    localparam logic [DATA_W-1:0] CTS_DELAY_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] STAT_RESET = 16'h0000;
    localparam logic [7:0] NULL_DROP = 8'hcc;

    typedef enum logic [3:0] {
        native_routed_mode = 4'h0,
        inter_network_mode = 4'h1,
        peripheral_mode = 4'h2,
        transparent_mode = 4'h3,
        share_mode = 4'h4,
        power_meter_mode = 4'h5,
        controller_protocol_mode = 4'h6,
        gateway_mode = 4'h7,
        multidrop_mode = 4'h8,
        modbus_mode = 4'h9,
        remote_rack_mode = 4'ha
    } port_mode_t;

    typedef enum logic [1:0] {
        pt_to_pt_drv = 2'h0,
        four_wire_drv = 2'h1,
        half_duplex_drv = 2'h2,
        two_wire_drv = 2'h3
    } driver_mode_t;

    typedef enum logic [1:0] {
        cts_off = 2'b00,
        cts_wait = 2'b01,
        cts_go = 2'b11
    } cts_state_t;

    typedef struct packed {
        port_mode_t mode;
        driver_mode_t driver;
        logic [7:0] drop;
    } port_cfg_t;

    typedef struct packed {
        logic write;
        logic [REG_NUM_W-1:0] num;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [DATA_W-1:0] wdata;
    } rack_req_t;
endpackage

// ### rtl/serial_port_handshake_mailbox.sv
// per-port handshake control, pad/delay registers, statistics and mailbox
`timescale 1ns/10ps

module serial_port_handshake_mailbox
    import serial_port_handshake_mailbox_pkg::*;
#(
    parameter int STEP_CYCLES = CTS_STEP_CYCLES,
    parameter int MBOX_REGS = MBOX_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input port_cfg_t i_port_cfg [NUM_PORTS],
    input wire logic [NUM_PORTS-1:1] i_cts_active,
    input wire logic [NUM_PORTS-1:0] i_tx_pending,
    input wire logic [NUM_PORTS-1:0] i_rx_buffer_high,
    input wire logic [NUM_PORTS-1:0] i_byte_sent,
    input wire logic [NUM_PORTS-1:0] i_checksum_sent,
    input wire logic [NUM_PORTS-1:0] i_ack_received,
    output logic [NUM_PORTS-1:0] o_tx_enable,
    output logic [NUM_PORTS-1:1] o_rts_active,
    output logic [NUM_PORTS-1:1] o_txd_oe,
    output logic [DATA_W-1:0] o_pad_count [NUM_PORTS],
    input wire logic i_route_valid,
    input wire logic [3:0] i_route_len,
    input wire logic [7:0] i_route_last_drop,
    output logic o_route_done,
    output logic o_route_local,
    input wire logic i_sreg_valid,
    input reg_req_t i_sreg_req,
    output logic o_sreg_ack,
    output logic o_sreg_err,
    output logic [DATA_W-1:0] o_sreg_rdata,
    input wire logic i_rack_valid,
    input rack_req_t i_rack_req,
    input wire logic [15:0] i_slot_start,
    output logic o_rack_ack,
    output logic o_rack_err,
    output logic [DATA_W-1:0] o_rack_rdata,
    output logic [RACK_WINDOW-1:0] o_rack_input_mask
);
    localparam int MBOX_IDX_W = $clog2(MBOX_REGS);
    localparam int TICK_W = $clog2(STEP_CYCLES + 1);

    initial begin
        if (STEP_CYCLES < 1 || MBOX_REGS < RACK_WINDOW || MBOX_REGS > MBOX_DEPTH) begin
            $error("serial_port_handshake_mailbox: unsupported parameter value");
        end
    end

    function automatic logic delay_mode(input port_mode_t m);
        return m inside {multidrop_mode, peripheral_mode, share_mode, modbus_mode, remote_rack_mode};
    endfunction

    function automatic logic [DATA_W-1:0] pad_floor(input logic [DATA_W-1:0] v);
        return (v < PAD_MIN) ? PAD_MIN : v;
    endfunction

    function automatic logic [DATA_W-1:0] cts_delay(input port_mode_t m, input logic [DATA_W-1:0] rr, pad);
        return (m == remote_rack_mode) ? rr : pad;
    endfunction

    logic [NUM_PORTS-1:1] cts_meta_reg;
    logic [NUM_PORTS-1:1] cts_reg;
    logic [TICK_W-1:0] tick_cnt_reg;
    logic tick_reg;
    cts_state_t cts_state_reg [NUM_PORTS];
    logic [DATA_W-1:0] delay_cnt_reg [NUM_PORTS];
    logic [DATA_W-1:0] pad_reg [NUM_PORTS];
    logic [DATA_W-1:0] rr_delay_reg [NUM_PORTS];
    logic [DATA_W-1:0] stat_reg [NUM_PORTS];
    logic [DATA_W-1:0] stat_cnt_reg [NUM_PORTS];
    logic [NUM_PORTS-1:0] stat_run_reg;
    logic [DATA_W-1:0] mbox_reg [MBOX_REGS];
    logic [MBOX_REGS-1:0] mbox_input_reg;

    // cts pins come from another domain: two flops, nothing reads the first
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cts_meta_reg <= '0;
            cts_reg <= '0;
        end else begin
            cts_meta_reg <= i_cts_active;
            cts_reg <= cts_meta_reg;
        end
    end

    // free-running delay step; first step after cts may be short by up to one step
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_W'(STEP_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    // clear-to-send gate with delay for ports 1 to 4; port 0 is held off and never gated
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                cts_state_reg[p] <= cts_off;
                delay_cnt_reg[p] <= '0;
            end
        end else begin
            cts_state_reg[0] <= cts_off;
            delay_cnt_reg[0] <= '0;
            for (int p = 1; p < NUM_PORTS; p++) begin
                unique case (cts_state_reg[p])
                    cts_off: begin
                        delay_cnt_reg[p] <= cts_delay(i_port_cfg[p].mode, rr_delay_reg[p], pad_reg[p]);
                        if (cts_reg[p] && delay_mode(i_port_cfg[p].mode) &&
                            cts_delay(i_port_cfg[p].mode, rr_delay_reg[p], pad_reg[p]) != '0) begin
                            cts_state_reg[p] <= cts_wait;
                        end else if (cts_reg[p]) begin
                            cts_state_reg[p] <= cts_go;
                        end
                    end
                    cts_wait: begin
                        if (!cts_reg[p]) begin
                            cts_state_reg[p] <= cts_off;
                        end else if (tick_reg) begin
                            delay_cnt_reg[p] <= delay_cnt_reg[p] - 1'b1;
                            if (delay_cnt_reg[p] == 16'h0001) begin
                                cts_state_reg[p] <= cts_go;
                            end
                        end
                    end
                    cts_go: begin
                        if (!cts_reg[p]) begin
                            cts_state_reg[p] <= cts_off;
                        end
                    end
                    default: begin
                        cts_state_reg[p] <= cts_off;
                    end
                endcase
            end
        end
    end

    // transmit permission is a handshake output, so it stays combinational
    always_comb begin
        o_tx_enable[0] = i_tx_pending[0];
        for (int p = 1; p < NUM_PORTS; p++) begin
            o_tx_enable[p] = i_tx_pending[p] && (cts_state_reg[p] == cts_go);
        end
    end

    // rts and transmit driver pins
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rts_active <= '0;
            o_txd_oe <= '1;
        end else begin
            for (int p = 1; p < NUM_PORTS; p++) begin
                if (delay_mode(i_port_cfg[p].mode)) begin
                    o_rts_active[p] <= i_tx_pending[p];
                end else begin
                    o_rts_active[p] <= !i_rx_buffer_high[p];
                end
                if (i_port_cfg[p].driver inside {four_wire_drv, two_wire_drv}) begin
                    o_txd_oe[p] <= cts_reg[p];
                end else begin
                    o_txd_oe[p] <= 1'b1;
                end
            end
        end
    end

    // acknowledgement delay statistic
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            stat_run_reg <= '0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                stat_reg[p] <= STAT_RESET;
                stat_cnt_reg[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (i_ack_received[p] && stat_run_reg[p]) begin
                    stat_reg[p] <= stat_cnt_reg[p];
                end
                if (i_checksum_sent[p] || i_ack_received[p]) begin
                    stat_run_reg[p] <= i_checksum_sent[p];
                    stat_cnt_reg[p] <= '0;
                end else if (stat_run_reg[p] && i_byte_sent[p] && stat_cnt_reg[p] != '1) begin
                    stat_cnt_reg[p] <= stat_cnt_reg[p] + 1'b1;
                end
            end
        end
    end

    // serial-side register access
    logic sreg_mbox;
    logic [MBOX_IDX_W-1:0] sreg_idx;
    logic [DATA_W-1:0] sreg_rd;
    logic sreg_hit;
    always_comb begin
        sreg_mbox = (i_sreg_req.num >= MBOX_FIRST) && (i_sreg_req.num <= REG_NUM_W'(MBOX_REGS));
        sreg_idx = MBOX_IDX_W'(i_sreg_req.num - MBOX_FIRST);
        sreg_rd = '0;
        sreg_hit = sreg_mbox;
        if (sreg_mbox) begin
            sreg_rd = mbox_reg[sreg_idx];
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (i_sreg_req.num == STAT_REG[p]) begin
                sreg_rd = stat_reg[p];
                sreg_hit = 1'b1;
            end
            if (i_sreg_req.num == PAD_REG[p]) begin
                sreg_rd = pad_reg[p];
                sreg_hit = 1'b1;
            end
            if (p > 0 && i_sreg_req.num == RR_DELAY_REG[p]) begin
                sreg_rd = rr_delay_reg[p];
                sreg_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sreg_ack <= 1'b0;
            o_sreg_err <= 1'b0;
            o_sreg_rdata <= '0;
        end else begin
            o_sreg_ack <= i_sreg_valid;
            o_sreg_err <= i_sreg_valid && !sreg_hit;
            if (i_sreg_valid) begin
                o_sreg_rdata <= i_sreg_req.write ? '0 : sreg_rd;
            end
        end
    end

    // pad and delay configuration; statistics ignore writes
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                pad_reg[p] <= PAD_RESET;
                rr_delay_reg[p] <= CTS_DELAY_RESET;
                o_pad_count[p] <= PAD_RESET;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                o_pad_count[p] <= pad_floor(pad_reg[p]);
                if (i_sreg_valid && i_sreg_req.write && i_sreg_req.num == PAD_REG[p]) begin
                    pad_reg[p] <= i_sreg_req.wdata;
                end
                if (p > 0 && i_sreg_valid && i_sreg_req.write && i_sreg_req.num == RR_DELAY_REG[p]) begin
                    rr_delay_reg[p] <= i_sreg_req.wdata;
                end
            end
        end
    end

    // rack-side access: window of 15 starting at the slot start address
    logic [15:0] rack_off;
    logic rack_hit;
    logic [MBOX_IDX_W-1:0] rack_idx;
    logic rack_wr_ok;
    logic sreg_mbox_wr;
    always_comb begin
        rack_off = i_rack_req.addr - i_slot_start;
        rack_hit = (i_rack_req.addr >= i_slot_start) && (rack_off < 16'(RACK_WINDOW));
        rack_idx = MBOX_IDX_W'(rack_off);
        rack_wr_ok = i_rack_valid && i_rack_req.write && rack_hit && !mbox_input_reg[rack_idx];
        sreg_mbox_wr = i_sreg_valid && i_sreg_req.write && sreg_mbox;
    end

    // mailbox storage; a serial write wins over a rack write to the same register
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < MBOX_REGS; i++) begin
                mbox_reg[i] <= '0;
            end
        end else begin
            if (rack_wr_ok) begin
                mbox_reg[rack_idx] <= i_rack_req.wdata;
            end
            if (sreg_mbox_wr) begin
                mbox_reg[sreg_idx] <= i_sreg_req.wdata;
            end
        end
    end

    // direction bits clear only on power-cycle reset
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            mbox_input_reg <= '0;
        end else if (sreg_mbox_wr) begin
            mbox_input_reg[sreg_idx] <= 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rack_ack <= 1'b0;
            o_rack_err <= 1'b0;
            o_rack_rdata <= '0;
            o_rack_input_mask <= '0;
        end else begin
            o_rack_ack <= i_rack_valid;
            o_rack_err <= i_rack_valid && !rack_hit;
            o_rack_input_mask <= mbox_input_reg[RACK_WINDOW-1:0];
            if (i_rack_valid) begin
                o_rack_rdata <= rack_hit ? mbox_reg[rack_idx] : '0;
            end
        end
    end

    // local servicing decision for an arriving route
    logic drop_owned;
    always_comb begin
        drop_owned = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (i_port_cfg[p].drop == i_route_last_drop) begin
                drop_owned = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_route_done <= 1'b0;
            o_route_local <= 1'b0;
        end else begin
            o_route_done <= i_route_valid;
            if (i_route_valid) begin
                o_route_local <= (i_route_len == 4'h0) || (i_route_last_drop == NULL_DROP) || !drop_owned;
            end
        end
    end

    // checks
    go_needs_cts_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        o_tx_enable[1] |-> cts_reg[1] || $past(cts_reg[1]))
        else $error("port 1 transmits while cts inactive");
    cts_drop_holds_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        !cts_reg[1] |=> !o_tx_enable[1]) else $error("port 1 transmit not held after cts dropped");
    delay_wait_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        cts_state_reg[1] == cts_wait && !tick_reg && cts_reg[1] |=> cts_state_reg[1] == cts_wait)
        else $error("cts delay ended without a step");
    zero_delay_go_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        cts_state_reg[1] == cts_off && cts_reg[1] && delay_mode(i_port_cfg[1].mode) &&
        i_port_cfg[1].mode != remote_rack_mode && pad_reg[1] == '0 |=> cts_state_reg[1] == cts_go)
        else $error("zero cts delay still delayed");
    driver_oe_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_port_cfg[3].driver == four_wire_drv && $stable(i_port_cfg[3].driver) |=> o_txd_oe[3] == $past(cts_reg[3]))
        else $error("four-wire driver enable does not follow cts");
    driver_on_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_port_cfg[1].driver == pt_to_pt_drv |=> o_txd_oe[1]) else $error("point-to-point driver disabled");
    rts_flow_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        !delay_mode(i_port_cfg[2].mode) && i_rx_buffer_high[2] |=> !o_rts_active[2])
        else $error("rts not dropped on full buffers");
    rts_ptt_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        delay_mode(i_port_cfg[1].mode) |=> o_rts_active[1] == $past(i_tx_pending[1]))
        else $error("push-to-talk rts does not follow pending data");
    pad_floor_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ##1 o_pad_count[0] >= PAD_MIN) else $error("pad count below ten");
    dir_sticky_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        mbox_input_reg[0] |=> mbox_input_reg[0]) else $error("mailbox direction reverted");
    rack_window_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_rack_valid && (i_rack_req.addr - i_slot_start) >= 16'(RACK_WINDOW) |=> o_rack_err)
        else $error("rack reached beyond its window");
    null_drop_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_route_valid && i_route_last_drop == NULL_DROP |=> o_route_done && o_route_local)
        else $error("null drop not serviced locally");
endmodule // serial_port_handshake_mailbox

// ### testbench/serial_far_end.sv
// far-end modem model: keys up on rts and answers with cts, promptly or slowly
`timescale 1ns/10ps
module serial_far_end (
    input wire logic i_clock,
    input wire logic i_slow,
    input wire logic [4:1] i_hold,
    input wire logic [4:1] i_rts_active,
    output logic [4:1] o_cts_active
);
    logic [4:1] stage_reg [4];
    always_ff @(posedge i_clock) begin
        stage_reg <= '{i_rts_active, stage_reg[0], stage_reg[1], stage_reg[2]};
    end
    // hold only when the bench asks; cts drops with rts, four cycles later when slow, so restraint never lasts
    assign o_cts_active = (i_slow ? stage_reg[3] : i_rts_active) & ~i_hold;
endmodule // serial_far_end

// ### testbench/serial_port_handshake_mailbox_test.sv
// self-checking bench for the serial port handshake and mailbox block
`timescale 1ns/10ps
`define CHK(nm, ex, gt) check_count++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end
module serial_port_handshake_mailbox_test;
    import serial_port_handshake_mailbox_pkg::*;
    typedef struct {logic rk; logic w; logic [15:0] a; logic [15:0] d; logic e; logic [15:0] r;} row_t;
    logic clock = 1'b0, resetn = 1'b0, slow = 1'b0, rv = 1'b0, sv = 1'b0, kv = 1'b0;
    logic done, local_out, sack, serr, kack, kerr;
    logic [4:1] hold = 4'h0, cts, rts, oe;
    logic [4:0] pend = 5'h0, rxh = 5'h0, bsent = 5'h0, csum = 5'h0, ackr = 5'h0, txen;
    logic [3:0] rlen = 4'h0;
    logic [7:0] rlast = 8'h00;
    logic [15:0] slot = 16'h00f5, srd, krd;
    logic [DATA_W-1:0] pad [NUM_PORTS];
    logic [14:0] mask;
    port_cfg_t cfg [NUM_PORTS];
    reg_req_t sreq = '0;
    rack_req_t kreq = '0;
    int error_cnt = 0, check_count = 0, cycles = 0;
    row_t rows [14] = '{
        '{0, 1, 16'h0001, 16'h1234, 0, 16'h0000}, '{0, 0, 16'h0001, 16'h0000, 0, 16'h1234},
        '{0, 1, 16'h0800, 16'hbeef, 0, 16'h0000}, '{0, 0, 16'h0800, 16'h0000, 0, 16'hbeef},
        '{0, 0, 16'h0000, 16'h0000, 1, 16'h0000}, '{0, 1, 16'h0801, 16'h0001, 1, 16'h0000},
        '{0, 1, 16'h1f60, 16'h0005, 0, 16'h0000}, '{0, 0, 16'h1f60, 16'h0000, 0, 16'h0005},
        '{0, 1, 16'h1f80, 16'h0002, 0, 16'h0000}, '{0, 1, 16'h1f6a, 16'h0007, 0, 16'h0000},
        '{0, 0, 16'h1f6a, 16'h0000, 0, 16'h0007}, '{1, 1, 16'h00f7, 16'h00aa, 0, 16'h0000},
        '{0, 0, 16'h0003, 16'h0000, 0, 16'h00aa}, '{1, 0, 16'h0104, 16'h0000, 1, 16'h0000}
    };
    serial_port_handshake_mailbox #(.STEP_CYCLES(20)) dut_u (.i_clock(clock), .i_resetn(resetn),
        .i_port_cfg(cfg), .i_cts_active(cts), .i_tx_pending(pend), .i_rx_buffer_high(rxh),
        .i_byte_sent(bsent), .i_checksum_sent(csum), .i_ack_received(ackr), .o_tx_enable(txen),
        .o_rts_active(rts), .o_txd_oe(oe), .o_pad_count(pad), .i_route_valid(rv), .i_route_len(rlen),
        .i_route_last_drop(rlast), .o_route_done(done), .o_route_local(local_out), .i_sreg_valid(sv),
        .i_sreg_req(sreq), .o_sreg_ack(sack), .o_sreg_err(serr), .o_sreg_rdata(srd), .i_rack_valid(kv),
        .i_rack_req(kreq), .i_slot_start(slot), .o_rack_ack(kack), .o_rack_err(kerr), .o_rack_rdata(krd),
        .o_rack_input_mask(mask));
    serial_far_end far_u (.i_clock(clock), .i_slow(slow), .i_hold(hold), .i_rts_active(rts), .o_cts_active(cts));
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic xfer(input row_t t);
        int k;
        sreq = '{write: t.w, num: t.a[12:0], wdata: t.d};
        kreq = '{write: t.w, addr: t.a, wdata: t.d};
        sv = !t.rk;
        kv = t.rk;
        @(negedge clock);
        sv = 1'b0;
        kv = 1'b0;
        // bounded wait for the registered answer
        for (k = 0; k < 3 && (t.rk ? kack : sack) !== 1'b1; k++) @(negedge clock);
        `CHK("ack", 1'b1, t.rk ? kack : sack)
        `CHK("err", t.e, t.rk ? kerr : serr)
        if (!t.e && !t.w) begin
            `CHK("rdata", t.r, t.rk ? krd : srd)
        end
        @(negedge clock);
    endtask
    task automatic route(input logic [3:0] n, input logic [7:0] last, input logic exp);
        rlen = n;
        rlast = last;
        rv = 1'b1;
        @(negedge clock);
        rv = 1'b0;
        `CHK("route_done", 1'b1, done)
        `CHK("route_local", exp, local_out)
        @(negedge clock);
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask
    initial begin
        foreach (cfg[i]) cfg[i] = '{mode: native_routed_mode, driver: pt_to_pt_drv, drop: 8'(i)};
        cfg[1].mode = multidrop_mode;
        cfg[3].driver = four_wire_drv;
        step(6);
        resetn = 1'b1;
        `CHK("pad_reset", PAD_RESET, pad[1])
        `CHK("oe_reset", 4'hf, oe)
        `CHK("mask_reset", 15'h0000, mask)
        foreach (rows[i]) xfer(rows[i]);
        `CHK("pad_min", PAD_MIN, pad[0])
        xfer('{1, 1, 16'h00f5, 16'hffff, 0, 16'h0000});
        xfer('{1, 0, 16'h00f5, 16'h0000, 0, 16'h1234});
        `CHK("mask", 3'b001, mask[2:0])
        pend = 5'h03;
        slow = 1'b1;
        step(12);
        `CHK("port0_tx", 1'b1, txen[0])
        `CHK("rts_ptt", 1'b1, rts[1])
        `CHK("tx_held", 1'b0, txen[1])
        step(60);
        `CHK("tx_go", 1'b1, txen[1])
        hold[1] = 1'b1;
        step(5);
        `CHK("tx_restrain", 1'b0, txen[1])
        hold[1] = 1'b0;
        pend = 5'h00;
        step(3);
        `CHK("rts_idle", 1'b0, rts[1])
        `CHK("rts_flow", 1'b1, rts[2])
        rxh[2] = 1'b1;
        hold[4:3] = 2'b11;
        step(5);
        `CHK("rts_flow_off", 1'b0, rts[2])
        `CHK("oe_gated", 2'b10, oe[4:3])
        hold = 4'h0;
        step(5);
        `CHK("oe_on", 1'b1, oe[3])
        rxh[2] = 1'b0; // device held off, so the buffers drain
        step(2);
        `CHK("rts_flow_on", 1'b1, rts[2])
        route(4'h0, 8'h00, 1'b1);
        route(4'h2, NULL_DROP, 1'b1);
        route(4'h2, 8'h6f, 1'b1);
        route(4'h2, 8'h02, 1'b0);
        csum[4] = 1'b1;
        step(1);
        csum[4] = 1'b0;
        repeat (3) begin
            bsent[4] = 1'b1;
            step(1);
            bsent[4] = 1'b0;
            step(1);
        end
        ackr[4] = 1'b1;
        step(1);
        ackr[4] = 1'b0;
        step(1);
        xfer('{0, 0, 16'h0878, 16'h0000, 0, 16'h0003});
        xfer('{0, 1, 16'h1f80, 16'h0000, 0, 16'h0000});
        `CHK("pad_floor", PAD_MIN, pad[1])
        slow = 1'b0;
        pend[1] = 1'b1;
        step(5);
        `CHK("tx_no_delay", 1'b1, txen[1])
        pend[1] = 1'b0;
        step(5);
        cfg[1].mode = remote_rack_mode;
        pend[1] = 1'b1;
        step(5);
        `CHK("rr_delay_held", 1'b0, txen[1])
        step(150);
        `CHK("rr_delay_go", 1'b1, txen[1])
        pend[1] = 1'b0;
        resetn = 1'b0;
        step(2);
        resetn = 1'b1;
        `CHK("mask_cleared", 15'h0000, mask)
        `CHK("pad_reset2", PAD_RESET, pad[1])
        give_verdict();
    end
endmodule // serial_port_handshake_mailbox_test
